// >>> shared/eel_pkg.sv
// Purpose: constants shared by the edge event line detector
// Assumes: 32-bit register port with byte addresses
// Notes: offsets are byte addresses of aligned words
package eel_pkg;

	// ----------------------------------------------------------------
	// line counts and widths
	// ----------------------------------------------------------------
	localparam int NUM_LINES = 23;
	localparam int NUM_EXT = 16;
	localparam int NUM_INT = NUM_LINES - NUM_EXT;
	localparam int NUM_PINS = 168;
	localparam int SEL_W = 8;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFF_INT_EN = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_EVT_EN = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_RISE_SEL = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_FALL_SEL = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_PEND = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_PEND_CLR = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_PIN_SEL0 = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_PIN_SEL1 = 8'h24;
	localparam logic [ADDR_W-1:0] OFF_PIN_SEL2 = 8'h28;
	localparam logic [ADDR_W-1:0] OFF_PIN_SEL3 = 8'h2c;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [NUM_LINES-1:0] RST_LINES = 23'h000000;
	localparam logic [SEL_W-1:0] RST_PIN_SEL = 8'h00;
	localparam logic [DATA_W-1:0] RST_RDATA = 32'h00000000;

endpackage : eel_pkg

// >>> shared/eel_cap_if.sv
// Purpose: carries line sources, edge choice and capture flags
// Assumes: one instance between the core and the capture cells
// Notes: clr is an asynchronous clear of the capture cells
`timescale 1ns/1ps
`default_nettype none
interface eel_cap_if;
	import eel_pkg::*;
	logic [NUM_LINES-1:0] src;
	logic [NUM_LINES-1:0] rise_en;
	logic [NUM_LINES-1:0] fall_en;
	logic [NUM_LINES-1:0] clr;
	logic [NUM_LINES-1:0] flag;

	// ----------------------------------------------------------------
	// views of the two sides
	// ----------------------------------------------------------------
	modport core (output src, output rise_en, output fall_en,
		output clr, input flag);
	modport cap (input src, input rise_en, input fall_en,
		input clr, output flag);
endinterface : eel_cap_if
`default_nettype wire

// >>> src/eel_edge_capture.sv
// Purpose: asynchronous edge catchers, one pair per line
// Assumes: clr is held until the synchronised flag has been seen
// Notes: an edge that lands while clr is high is not kept
`timescale 1ns/1ps
`default_nettype none
module eel_edge_capture
	import eel_pkg::*;
(
	// capture side of the line bundle
	eel_cap_if.cap cap
);

	// ----------------------------------------------------------------
	// per-line catchers
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < NUM_LINES; i++) begin : g_line
			logic rise_hit;
			logic fall_hit;
			logic rise_clr;
			logic fall_clr;
			// a deselected edge is held clear, so it cannot fire later
			assign rise_clr = cap.clr[i] | ~cap.rise_en[i];
			assign fall_clr = cap.clr[i] | ~cap.fall_en[i];
			always_ff @(posedge cap.src[i] or posedge rise_clr) begin
				if (rise_clr) begin
					rise_hit <= 1'b0;
				end else begin
					rise_hit <= 1'b1;
				end
			end
			always_ff @(negedge cap.src[i] or posedge fall_clr) begin
				if (fall_clr) begin
					fall_hit <= 1'b0;
				end else begin
					fall_hit <= 1'b1;
				end
			end
			assign cap.flag[i] = (rise_hit & cap.rise_en[i]) |
				(fall_hit & cap.fall_en[i]);
		end
	endgenerate

endmodule : eel_edge_capture
`default_nettype wire

// >>> src/eel_line_detector.sv
// Purpose: edge event line detector with pin selector and registers
// Assumes: register port strobes are one cycle, read data a cycle later
// Notes: sixteen selectable pin lines plus seven internal event lines
// Notes on behaviour
// - there are 23 independent lines, each raising an interrupt or event.
// - each line picks rising, falling or both edges on its own.
// - each line has its own interrupt mask and its own event mask.
// - each line has a sticky pending bit readable until it is cleared.
// - edges are caught asynchronously so pulses shorter than a clock count.
// - a selector routes any of 168 pins onto each of the 16 pin lines.
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module eel_line_detector
	import eel_pkg::*;
(
	// clock, reset, enable
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	// event sources
	input wire logic [NUM_PINS-1:0] gpio_in,
	input wire logic [NUM_INT-1:0] int_src,
	// register port
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [DATA_W-1:0] rdata,
	// requests to the processor
	output logic [NUM_LINES-1:0] irq_line,
	output logic [NUM_LINES-1:0] evt_out,
	output logic irq
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [NUM_LINES-1:0] int_en;
	logic [NUM_LINES-1:0] evt_en;
	logic [NUM_LINES-1:0] rise_sel;
	logic [NUM_LINES-1:0] fall_sel;
	logic [NUM_LINES-1:0] pend;
	logic [NUM_LINES-1:0] sync_a;
	logic [NUM_LINES-1:0] sync_b;
	logic [NUM_LINES-1:0] sync_c;
	logic [NUM_LINES-1:0] cap_clr;
	logic [NUM_LINES-1:0] hit;
	logic [NUM_LINES-1:0] clr_mask;
	logic [NUM_LINES-1:0] next_pend;
	logic [NUM_EXT-1:0][SEL_W-1:0] pin_sel;
	logic [NUM_EXT-1:0] ext_src;
	logic [DATA_W-1:0] next_rdata;
	logic psel_hit;

	eel_cap_if cap_bus ();

	// ----------------------------------------------------------------
	// pin selector
	// ----------------------------------------------------------------
	genvar k;
	generate
		for (k = 0; k < NUM_EXT; k++) begin : g_sel
			assign ext_src[k] = (pin_sel[k] < SEL_W'(NUM_PINS)) ?
				gpio_in[pin_sel[k]] : 1'b0;
			// selector field write
			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					pin_sel[k] <= RST_PIN_SEL;
				end else if (ce && wr && psel_hit &&
					addr[3:2] == 2'(k / 4)) begin
					pin_sel[k] <= wdata[SEL_W*(k%4) +: SEL_W];
				end
			end
		end
	endgenerate

	// selector words share one address block
	assign psel_hit = ({addr[7:4], 4'h0} == OFF_PIN_SEL0) &&
		(addr[1:0] == 2'b00);

	// ----------------------------------------------------------------
	// capture cells
	// ----------------------------------------------------------------
	// pin lines then internal lines
	assign cap_bus.src = {int_src, ext_src};
	assign cap_bus.rise_en = rise_sel;
	assign cap_bus.fall_en = fall_sel;
	// cells are cleared by reset or by the acknowledge
	assign cap_bus.clr = cap_clr | {NUM_LINES{rst}};

	eel_edge_capture u_cap (
		.cap (cap_bus.cap)
	);

	// ----------------------------------------------------------------
	// synchronisation and acknowledge
	// ----------------------------------------------------------------
	// bring flags into clock domain
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sync_a <= RST_LINES;
			sync_b <= RST_LINES;
			sync_c <= RST_LINES;
		end else if (ce) begin
			sync_a <= cap_bus.flag;
			sync_b <= sync_a;
			sync_c <= sync_b;
		end
	end

	// acknowledge clears the cell while its flag is seen
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cap_clr <= RST_LINES;
		end else if (ce) begin
			cap_clr <= sync_b;
		end
	end

	// one cycle per caught edge
	assign hit = sync_b & ~sync_c;

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	// mask and edge choice
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			int_en <= RST_LINES;
			evt_en <= RST_LINES;
			rise_sel <= RST_LINES;
			fall_sel <= RST_LINES;
		end else if (ce && wr) begin
			if (addr == OFF_INT_EN) begin
				int_en <= wdata[NUM_LINES-1:0];
			end
			if (addr == OFF_EVT_EN) begin
				evt_en <= wdata[NUM_LINES-1:0];
			end
			if (addr == OFF_RISE_SEL) begin
				rise_sel <= wdata[NUM_LINES-1:0];
			end
			if (addr == OFF_FALL_SEL) begin
				fall_sel <= wdata[NUM_LINES-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// pending status
	// ----------------------------------------------------------------
	// write one clears
	assign clr_mask = (wr && addr == OFF_PEND_CLR) ?
		wdata[NUM_LINES-1:0] : RST_LINES;
	assign next_pend = (pend & ~clr_mask) | hit;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pend <= RST_LINES;
		end else if (ce) begin
			pend <= next_pend;
		end
	end

	// ----------------------------------------------------------------
	// request outputs
	// ----------------------------------------------------------------
	// masked lines forward nothing
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			irq_line <= RST_LINES;
			irq <= 1'b0;
			evt_out <= RST_LINES;
		end else if (ce) begin
			irq_line <= next_pend & int_en;
			irq <= |(next_pend & int_en);
			evt_out <= hit & evt_en;
		end
	end

	// ----------------------------------------------------------------
	// register read
	// ----------------------------------------------------------------
	always_comb begin
		next_rdata = RST_RDATA;
		if (psel_hit) begin
			next_rdata = pin_sel[4*addr[3:2] +: 4];
		end else begin
			unique case (addr)
				OFF_INT_EN: next_rdata[NUM_LINES-1:0] = int_en;
				OFF_EVT_EN: next_rdata[NUM_LINES-1:0] = evt_en;
				OFF_RISE_SEL: next_rdata[NUM_LINES-1:0] = rise_sel;
				OFF_FALL_SEL: next_rdata[NUM_LINES-1:0] = fall_sel;
				OFF_PEND: next_rdata[NUM_LINES-1:0] = pend;
				default: next_rdata = RST_RDATA;
			endcase
		end
	end

	// read data stand one cycle after the strobe
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rdata <= RST_RDATA;
		end else if (ce) begin
			rdata <= rd ? next_rdata : RST_RDATA;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_pend_on_hit: assert property (
		@(posedge clk_sys) disable iff (rst)
		ce && hit != '0 |=> (pend & $past(hit)) == $past(hit))
		else $error("caught edge did not set pending");

	a_pend_holds: assert property (
		@(posedge clk_sys) disable iff (rst)
		ce && !(wr && addr == OFF_PEND_CLR)
		|=> (pend & $past(pend)) == $past(pend))
		else $error("pending bit dropped without a clear");

	a_pend_w1c: assert property (
		@(posedge clk_sys) disable iff (rst)
		ce && wr && addr == OFF_PEND_CLR && hit == '0
		|=> (pend & $past(wdata[NUM_LINES-1:0])) == '0)
		else $error("write one did not clear pending");

	a_irq_masked: assert property (
		@(posedge clk_sys) disable iff (rst)
		$past(ce) |-> (irq_line & ~$past(int_en)) == '0)
		else $error("masked line raised interrupt");

	a_evt_masked: assert property (
		@(posedge clk_sys) disable iff (rst)
		ce && evt_en == '0 |=> evt_out == '0)
		else $error("masked line raised event");

	a_irq_summary: assert property (
		@(posedge clk_sys) disable iff (rst)
		irq == (irq_line != '0))
		else $error("interrupt output disagrees with lines");

	a_flag_ack: assert property (
		@(posedge clk_sys) disable iff (rst)
		ce && sync_b != '0 |=> (cap_clr & $past(sync_b)) == $past(sync_b))
		else $error("caught flag was not acknowledged");

	a_sel_range: assert property (
		@(posedge clk_sys) disable iff (rst)
		pin_sel[0] >= SEL_W'(NUM_PINS) |-> !ext_src[0])
		else $error("out of range selector drove a line");

	a_pend_to_irq: assert property (
		@(posedge clk_sys) disable iff (rst)
		ce && (hit & int_en) != '0 |=> irq)
		else $error("enabled edge did not raise interrupt");

	c_irq_raised: cover property (@(posedge clk_sys) disable iff (rst)
		!irq ##1 irq);
	c_event_pulse: cover property (@(posedge clk_sys) disable iff (rst)
		evt_out != '0);
	c_clear_pend: cover property (@(posedge clk_sys) disable iff (rst)
		wr && addr == OFF_PEND_CLR && pend != '0);
	c_both_edges: cover property (@(posedge clk_sys) disable iff (rst)
		(rise_sel & fall_sel & hit) != '0);

endmodule : eel_line_detector
`default_nettype wire

// >>> verification/eel_pin_model.sv
// Purpose: pin and internal source model for the edge event line detector
// Assumes: the bench calls the tasks shortly after a clock edge
// Notes: levels change off the clock, as real pins do
`timescale 1ns/1ps
`default_nettype none
module eel_pin_model
	import eel_pkg::*;
(
	// pin levels toward the detector
	output logic [NUM_PINS-1:0] gpio_in,
	// internal event sources
	output logic [NUM_INT-1:0] int_src
);
	// ---------------------------------------------------------------
	// source levels
	// ---------------------------------------------------------------
	// all sources start low
	initial begin
		gpio_in = '0;
		int_src = '0;
	end

	// set one level: pins first, then internal lines
	task automatic drive(input int idx, input logic v);
		#2;
		if (idx < NUM_PINS)
			gpio_in[idx] = v;
		else
			int_src[idx-NUM_PINS] = v;
	endtask : drive

	// pulse far shorter than one clock period
	task automatic blip(input int idx);
		drive(idx, 1'b1);
		#1;
		gpio_in[idx] = 1'b0;
	endtask : blip
endmodule : eel_pin_model
`default_nettype wire

// >>> verification/test_edge_event_line_detector.sv
// Purpose: self-checking bench for the edge event line detector
// Assumes: register port answers reads one cycle after the strobe
// Notes: lines 0, 1, 15 come from pins 5, 6, 167; line 22 is internal
`timescale 1ns/1ps
`default_nettype none
module test_edge_event_line_detector;
	import eel_pkg::*;
	logic clk_sys, rst, ce, wr, rd, irq;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata, rdata;
	logic [NUM_PINS-1:0] gpio_in;
	logic [NUM_INT-1:0] int_src;
	logic [NUM_LINES-1:0] irq_line, evt_out;
	int n_mismatch = 0;
	int checks = 0;
	int n_evt = 0;
	int n_evt_other = 0;
	logic [7:0] offs [9] = '{OFF_INT_EN, OFF_EVT_EN, OFF_RISE_SEL,
		OFF_FALL_SEL, OFF_PEND, OFF_PEND_CLR, OFF_PIN_SEL0, OFF_PIN_SEL2,
		8'h3c};

	// ---------------------------------------------------------------
	// instances, clock, event counters
	// ---------------------------------------------------------------
	eel_pin_model pm (.gpio_in(gpio_in), .int_src(int_src));
	eel_line_detector dut (.clk_sys(clk_sys), .rst(rst), .ce(ce),
		.gpio_in(gpio_in), .int_src(int_src), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .irq_line(irq_line),
		.evt_out(evt_out), .irq(irq));

	// 200 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// count event pulses on line 22 and on all others
	always @(posedge clk_sys) begin
		if (evt_out[22] === 1'b1)
			n_evt++;
		if (|evt_out[21:0] !== 1'b0)
			n_evt_other++;
	end

	// ---------------------------------------------------------------
	// access and compare tasks
	// ---------------------------------------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask : wr_reg

	// read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1 chk(rdata, e);
	endtask : rd_chk

	// let an edge pass the synchronisers, then look at status and lines
	task automatic state(input logic [31:0] ep, input logic [22:0] el);
		repeat (8) @(posedge clk_sys);
		rd_chk(OFF_PEND, ep);
		chk({9'h000, irq_line}, {9'h000, el});
		chk({31'h00000000, irq}, {31'h00000000, |el});
	endtask : state

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude

	// ---------------------------------------------------------------
	// test sequence
	// ---------------------------------------------------------------
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = '0;
		wdata = '0;
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		// reset values, write-only and unmapped reads
		foreach (offs[i]) rd_chk(offs[i], RST_RDATA);
		// selectors first, edges enabled afterwards
		wr_reg(OFF_PIN_SEL0, 32'h00000605);
		wr_reg(OFF_PIN_SEL3, 32'ha7000000);
		wr_reg(OFF_RISE_SEL, 32'h00408001);
		wr_reg(OFF_FALL_SEL, 32'h00400002);
		wr_reg(OFF_INT_EN, 32'h00008001);
		wr_reg(OFF_EVT_EN, 32'h00400000);
		rd_chk(OFF_FALL_SEL, 32'h00400002);
		rd_chk(OFF_PIN_SEL3, 32'ha7000000);
		// writes are ignored while the clock enable is low
		@(posedge clk_sys) ce <= 1'b0;
		wr_reg(OFF_INT_EN, 32'h007fffff);
		ce <= 1'b1;
		rd_chk(OFF_INT_EN, 32'h00008001);
		wr_reg(OFF_PEND, 32'hffffffff);
		rd_chk(OFF_PEND, 32'h00000000);
		// rising edge on a falling-only line is ignored
		pm.drive(6, 1'b1);
		state(32'h00000000, 23'h000000);
		// pulse narrower than a clock period
		pm.blip(5);
		state(32'h00000001, 23'h000001);
		// masked line keeps pending but raises nothing
		pm.drive(6, 1'b0);
		state(32'h00000003, 23'h000001);
		// clearing by write-one only
		wr_reg(OFF_PEND_CLR, 32'h00000000);
		state(32'h00000003, 23'h000001);
		wr_reg(OFF_PEND_CLR, 32'h00000001);
		state(32'h00000002, 23'h000000);
		// highest pin through the selector
		pm.drive(167, 1'b1);
		state(32'h00008002, 23'h008000);
		// internal line on both edges, event only
		pm.drive(NUM_PINS + 6, 1'b1);
		state(32'h00408002, 23'h008000);
		wr_reg(OFF_PEND_CLR, 32'h00400000);
		pm.drive(NUM_PINS + 6, 1'b0);
		state(32'h00408002, 23'h008000);
		chk(n_evt, 2);
		chk(n_evt_other, 0);
		wr_reg(OFF_PEND_CLR, 32'h007fffff);
		state(32'h00000000, 23'h000000);
		// a selector past the last pin gives a quiet line
		wr_reg(OFF_PIN_SEL0, 32'h000006ff);
		pm.drive(5, 1'b1);
		state(32'h00000000, 23'h000000);
		conclude();
	end

	// watchdog, far beyond the expected run
	initial begin
		#20000;
		n_mismatch++;
		conclude();
	end
endmodule : test_edge_event_line_detector
`default_nettype wire
